// ### pcg_gating.sv
// Port command gating top: permission masks, mode selector, curve setup.
// Assumes command words arrive synchronous to pclk and APB drives access.
module pcg_gating #(
   parameter int NPORTS = pcg_pkg::NPORTS
) (
   input  wire logic                           pclk,
   input  wire logic                           presetn,
   input  wire logic                           psel,
   input  wire logic                           penable,
   input  wire logic                           pwrite,
   input  wire logic [7:0]                     paddr,
   input  wire logic [31:0]                    pwdata,
   output logic      [31:0]                    prdata,
   output logic                                pready,
   output logic                                pslverr,
   input  wire pcg_pkg::pcg_cmd_t [NPORTS-1:0] port_cmd,
   input  wire logic                           drive_reset,
   input  wire logic                           direction_test,
   input  wire logic                           accelerating,
   input  wire logic [15:0]                    out_freq,
   output logic                                cmd_stop,
   output logic                                cmd_start,
   output logic                                cmd_jog,
   output logic                                cmd_fwd,
   output logic                                cmd_rev,
   output logic                                cmd_fault_clear,
   output logic      [NPORTS-1:0]              write_grant,
   output logic      [NPORTS-1:0]              write_refuse,
   output logic      [2:0]                     drive_mode,
   output logic      [15:0]                    vhz_voltage
);

   // Software-facing registers.
   logic [15:0] write_pend_reg;
   logic [15:0] write_act_reg;
   logic [15:0] control_reg;
   logic [15:0] start_reg;
   logic [15:0] inch_reg;
   logic [15:0] rotation_reg;
   logic [15:0] err_clear_reg;
   logic [2:0]  algorithm_reg;
   logic [NPORTS-1:0] refused_reg;
   pcg_pkg::pcg_curve_t curve_reg;

   // Bus decode.
   logic        wr_en;
   logic        setup;
   logic        mapped;
   logic [31:0] rd_next;
   logic [7:0]  waddr;

   // Per-port gated requests.
   logic [NPORTS-1:0] pass_stop;
   logic [NPORTS-1:0] pass_start;
   logic [NPORTS-1:0] pass_jog;
   logic [NPORTS-1:0] pass_fwd;
   logic [NPORTS-1:0] pass_rev;
   logic [NPORTS-1:0] pass_fclr;
   logic [NPORTS-1:0] pass_wr;
   logic [NPORTS-1:0] req_wr;
   logic              fwd_any;
   logic              rev_any;
   logic              sec_fall;

   // Reserved bits never pass, whatever software wrote into a mask.
   function automatic logic usable(input logic [15:0] m, input int p);
      usable = m[p] && pcg_pkg::SOURCE_BITS[p];
   endfunction

   // Any address outside the map answers with an error.
   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a[1:0] == 2'b00) && (a <= pcg_pkg::OFS_VOLTAGE);
   endfunction

   assign setup = psel && !penable;
   assign wr_en = psel && penable && pready && pwrite && !pslverr;
   assign waddr = paddr;
   assign mapped = is_mapped(paddr);

   // The slave answers one cycle after setup; data and error are
   // prepared during setup so that both come straight from flip-flops.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= setup;
         pslverr <= setup && !mapped;
      end
   end

   // Read multiplexer; the data stand through the access phase.
   always_comb begin
      rd_next = 32'h00000000;
      unique case (paddr)
         pcg_pkg::OFS_WRITE_PEND:  rd_next[15:0] = write_pend_reg;
         pcg_pkg::OFS_WRITE_ACT:   rd_next[15:0] = write_act_reg;
         pcg_pkg::OFS_CONTROL:     rd_next[15:0] = control_reg;
         pcg_pkg::OFS_START:       rd_next[15:0] = start_reg;
         pcg_pkg::OFS_INCH:        rd_next[15:0] = inch_reg;
         pcg_pkg::OFS_ROTATION:    rd_next[15:0] = rotation_reg;
         pcg_pkg::OFS_ERR_CLEAR:   rd_next[15:0] = err_clear_reg;
         pcg_pkg::OFS_ALGORITHM:   rd_next[2:0]  = algorithm_reg;
         pcg_pkg::OFS_START_BOOST: rd_next[15:0] = curve_reg.start_boost;
         pcg_pkg::OFS_RUN_BOOST:   rd_next[15:0] = curve_reg.run_boost;
         pcg_pkg::OFS_BREAK_VOLT:  rd_next[15:0] = curve_reg.break_volt;
         pcg_pkg::OFS_BREAK_FREQ:  rd_next[15:0] = curve_reg.break_freq;
         pcg_pkg::OFS_RATED_VOLT:  rd_next[15:0] = curve_reg.rated_volt;
         pcg_pkg::OFS_RATED_FREQ:  rd_next[15:0] = curve_reg.rated_freq;
         pcg_pkg::OFS_STATUS:      rd_next[NPORTS-1:0] = refused_reg;
         pcg_pkg::OFS_VOLTAGE:     rd_next[15:0] = vhz_voltage;
         default:                  rd_next = 32'h00000000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (setup) begin
         prdata <= (pwrite || !mapped) ? 32'h00000000 : rd_next;
      end
   end

   // Command masks written by software take effect at once.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control_reg   <= pcg_pkg::RST_MASK;
         start_reg     <= pcg_pkg::RST_MASK;
         inch_reg      <= pcg_pkg::RST_MASK;
         rotation_reg  <= pcg_pkg::RST_MASK;
         err_clear_reg <= pcg_pkg::RST_MASK;
      end else if (wr_en) begin
         unique case (waddr)
            pcg_pkg::OFS_CONTROL:   control_reg   <= pwdata[15:0];
            pcg_pkg::OFS_START:     start_reg     <= pwdata[15:0];
            pcg_pkg::OFS_INCH:      inch_reg      <= pwdata[15:0];
            pcg_pkg::OFS_ROTATION:  rotation_reg  <= pwdata[15:0];
            pcg_pkg::OFS_ERR_CLEAR: err_clear_reg <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   // Curve settings; the defaults give one straight line to rated.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         curve_reg.start_boost <= pcg_pkg::RST_START_BOOST;
         curve_reg.run_boost   <= pcg_pkg::RST_RUN_BOOST;
         curve_reg.break_volt  <= pcg_pkg::RST_BREAK_VOLT;
         curve_reg.break_freq  <= pcg_pkg::RST_BREAK_FREQ;
         curve_reg.rated_volt  <= pcg_pkg::RST_RATED_VOLT;
         curve_reg.rated_freq  <= pcg_pkg::RST_RATED_FREQ;
      end else if (wr_en) begin
         unique case (waddr)
            pcg_pkg::OFS_START_BOOST:
               curve_reg.start_boost <= pwdata[15:0];
            pcg_pkg::OFS_RUN_BOOST:  curve_reg.run_boost  <= pwdata[15:0];
            pcg_pkg::OFS_BREAK_VOLT: curve_reg.break_volt <= pwdata[15:0];
            pcg_pkg::OFS_BREAK_FREQ: curve_reg.break_freq <= pwdata[15:0];
            pcg_pkg::OFS_RATED_VOLT: curve_reg.rated_volt <= pwdata[15:0];
            pcg_pkg::OFS_RATED_FREQ: curve_reg.rated_freq <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   // The pending write mask is only staged here; it does not gate yet.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         write_pend_reg <= pcg_pkg::RST_MASK;
      end else if (wr_en && waddr == pcg_pkg::OFS_WRITE_PEND) begin
         write_pend_reg <= pwdata[15:0];
      end
   end

   // Only the security bit of the active mask is writable; clearing it
   // after setting it is the software path to adopt the staged mask.
   assign sec_fall = wr_en && waddr == pcg_pkg::OFS_WRITE_ACT &&
                     write_act_reg[pcg_pkg::BIT_SECURITY] &&
                     !pwdata[pcg_pkg::BIT_SECURITY];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         write_act_reg <= pcg_pkg::RST_MASK;
      end else if (drive_reset || sec_fall) begin
         write_act_reg <= {1'b0, write_pend_reg[14:0]};
      end else if (wr_en && waddr == pcg_pkg::OFS_WRITE_ACT) begin
         write_act_reg[pcg_pkg::BIT_SECURITY] <=
            pwdata[pcg_pkg::BIT_SECURITY];
      end
   end

   // Commissioning forces test mode and leaves it there afterwards,
   // so software sees which algorithm is really running.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         algorithm_reg <= pcg_pkg::MODE_VECTOR;
      end else if (direction_test) begin
         algorithm_reg <= pcg_pkg::MODE_TEST;
      end else if (wr_en && waddr == pcg_pkg::OFS_ALGORITHM &&
                   pwdata[2:0] <= pcg_pkg::MODE_TEST) begin
         algorithm_reg <= pwdata[2:0];
      end
   end

   // Per-port valves for each command type except stop, which always passes.
   genvar p;
   generate
      for (p = 0; p < NPORTS; p++) begin : g_port
         logic ctl_ok;
         assign ctl_ok = usable(control_reg, p);
         assign pass_stop[p]  = port_cmd[p].stop;
         assign pass_start[p] = port_cmd[p].start && ctl_ok &&
                                usable(start_reg, p);
         assign pass_jog[p]   = port_cmd[p].jog && ctl_ok &&
                                usable(inch_reg, p);
         assign pass_fwd[p]   = port_cmd[p].fwd && ctl_ok &&
                                usable(rotation_reg, p);
         assign pass_rev[p]   = port_cmd[p].rev && ctl_ok &&
                                usable(rotation_reg, p);
         assign pass_fclr[p]  = port_cmd[p].fclr && ctl_ok &&
                                usable(err_clear_reg, p);
         assign req_wr[p]     = port_cmd[p].wr;
         assign pass_wr[p]    = port_cmd[p].wr &&
                                usable(write_act_reg, p);
      end
   endgenerate

   assign fwd_any = |pass_fwd;
   assign rev_any = |pass_rev;

   // Gated commands toward the drive; opposing directions cancel, since
   // guessing a winner could reverse a load nobody asked to reverse.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_stop        <= 1'b0;
         cmd_start       <= 1'b0;
         cmd_jog         <= 1'b0;
         cmd_fwd         <= 1'b0;
         cmd_rev         <= 1'b0;
         cmd_fault_clear <= 1'b0;
      end else begin
         cmd_stop        <= |pass_stop;
         cmd_start       <= |pass_start && !(|pass_stop);
         cmd_jog         <= |pass_jog;
         cmd_fwd         <= fwd_any && !rev_any;
         cmd_rev         <= rev_any && !fwd_any;
         cmd_fault_clear <= |pass_fclr;
      end
   end

   // Parameter write grants and refusals for each port.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         write_grant  <= '0;
         write_refuse <= '0;
      end else begin
         write_grant  <= pass_wr;
         write_refuse <= req_wr & ~pass_wr;
      end
   end

   // Sticky refusal record; a new refusal beats a clear in one cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         refused_reg <= '0;
      end else if (wr_en && waddr == pcg_pkg::OFS_STATUS) begin
         refused_reg <= (refused_reg & ~pwdata[NPORTS-1:0]) |
                        (req_wr & ~pass_wr);
      end else begin
         refused_reg <= refused_reg | (req_wr & ~pass_wr);
      end
   end

   // Mode output follows the selector.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drive_mode <= pcg_pkg::MODE_VECTOR;
      end else begin
         drive_mode <= algorithm_reg;
      end
   end

   // Curve runs only in volts-hertz mode.
   pcg_vhz_curve u_curve (
      .pclk         (pclk),
      .presetn      (presetn),
      .enable       (algorithm_reg == pcg_pkg::MODE_VHZ),
      .accelerating (accelerating),
      .freq         (out_freq),
      .curve        (curve_reg),
      .voltage      (vhz_voltage)
   );

endmodule // pcg_gating

// ### pcg_gating_monitor.sv
// Concurrent checks on the ports of the port command gating top.
// Assumes a bind into pcg_gating and a single pclk domain.
module pcg_gating_monitor #(
   parameter int NPORTS = 8
) (
   input wire logic                           pclk,
   input wire logic                           presetn,
   input wire logic                           psel,
   input wire logic                           penable,
   input wire logic [7:0]                     paddr,
   input wire logic                           pready,
   input wire logic                           pslverr,
   input wire pcg_pkg::pcg_cmd_t [NPORTS-1:0] port_cmd,
   input wire logic                           direction_test,
   input wire logic                           cmd_stop,
   input wire logic                           cmd_start,
   input wire logic                           cmd_jog,
   input wire logic                           cmd_fwd,
   input wire logic                           cmd_rev,
   input wire logic                           cmd_fault_clear,
   input wire logic [NPORTS-1:0]              write_grant,
   input wire logic [NPORTS-1:0]              write_refuse,
   input wire logic [2:0]                     drive_mode,
   input wire logic [15:0]                    vhz_voltage
);
   localparam logic [NPORTS-1:0] SRC = pcg_pkg::SOURCE_BITS[NPORTS-1:0];
   logic [NPORTS-1:0] stp;
   logic [NPORTS-1:0] go;
   logic [NPORTS-1:0] wrq;

   // Per-port request bits; go gathers the start, jog and fault-clear requests.
   always_comb begin
      for (int i = 0; i < NPORTS; i++) begin
         stp[i] = port_cmd[i].stop;
         go[i]  = port_cmd[i].start | port_cmd[i].jog | port_cmd[i].fclr;
         wrq[i] = port_cmd[i].wr;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence setup_s;
      psel && !penable;
   endsequence
   sequence bad_s;
      setup_s ##0 (paddr[1:0] != 2'h0 || paddr > 8'h3C);
   endsequence

   a_ready_one: assert property (setup_s |=> pready)
      else $error("pready missing after setup");
   a_ready_only: assert property (!(psel && !penable) |=> !pready)
      else $error("pready without setup");
   a_slverr_map: assert property (bad_s |=> pready && pslverr)
      else $error("unmapped access not flagged");
   a_stop_pass: assert property ((|(stp & SRC)) |=> cmd_stop)
      else $error("stop did not pass");
   a_stop_start: assert property ((|stp) |=> !cmd_start)
      else $error("start passed beside stop");
   a_dir_excl: assert property (!(cmd_fwd && cmd_rev))
      else $error("both directions issued");
   a_write_split: assert property (1'b1 |=>
      ((write_grant & write_refuse) == '0) &&
      ((write_grant & ~($past(wrq) & SRC)) == '0))
      else $error("write grant without request");
   a_reserved_none: assert property (((go & SRC) == '0)
      |=> !cmd_start && !cmd_jog && !cmd_fault_clear)
      else $error("command without a source port");
   a_test_force: assert property (direction_test
      |-> ##[1:2] drive_mode == 3'h4)
      else $error("test mode not forced");
   a_vhz_off: assert property ((drive_mode != 3'h3)[*4]
      |-> vhz_voltage == 16'h0000)
      else $error("curve voltage outside its mode");
endmodule // pcg_gating_monitor

// ### pcg_gating_tb.sv
// Self-checking bench of the gating top against a register model.
// Assumes pcg_pkg, pcg_src_model and pcg_gating_monitor are compiled.
module pcg_gating_tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef pcg_pkg::pcg_cmd_t [7:0] vec_t;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        drive_reset, direction_test, accelerating, ld, er;
   logic        cmd_stop, cmd_start, cmd_jog, cmd_fwd, cmd_rev, cmd_fclr;
   logic [7:0]  paddr, write_grant, write_refuse;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] out_freq, vhz_voltage;
   logic [2:0]  drive_mode;
   vec_t        cv, port_cmd, v;
   int          error_cnt, n_tests, act, b15;
   int          msk [16];

   pcg_src_model i_pcg_src_model (.*, .load(ld), .cmds(cv));
   pcg_gating i_pcg_gating (.*, .cmd_fault_clear(cmd_fclr));

   // Every comparison is counted; a mismatch is reported at once.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; the wait is bounded only to catch a hang.
   task automatic apb(input logic w, input logic [7:0] a, input int d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) error_cnt++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Write and mirror into the model; the active mask loads on a fall.
   task automatic wreg(input logic [7:0] a, input int d);
      apb(1'b1, a, d);
      if (a == pcg_pkg::OFS_WRITE_ACT) begin
         if (b15 == 1 && !d[15]) act = msk[0] & 32'h7FFF;
         b15 = d[15];
      end else if (a != pcg_pkg::OFS_ALGORITHM || d <= 4) begin
         msk[a>>2] = d & 32'hFFFF;
      end
   endtask

   task automatic rreg(input logic [7:0] a);
      apb(1'b0, a, 0);
      if (a == pcg_pkg::OFS_WRITE_ACT) chk(rd, act | (b15 << 15));
      else chk(rd, msk[a>>2]);
   endtask

   // Drive a command set through the sources and check the gate.
   task automatic send(input vec_t c);
      logic [7:0] s, st, jg, fw, rv, fc, wq, ctl, wa;
      logic       f, r;
      for (int i = 0; i < 8; i++) begin
         s[i] = c[i].stop;
         st[i] = c[i].start;
         jg[i] = c[i].jog;
         fw[i] = c[i].fwd;
         rv[i] = c[i].rev;
         fc[i] = c[i].fclr;
         wq[i] = c[i].wr;
      end
      ctl = msk[2][7:0] & pcg_pkg::SOURCE_BITS[7:0];
      wa = act[7:0] & pcg_pkg::SOURCE_BITS[7:0];
      f = |(fw & ctl & msk[5][7:0]);
      r = |(rv & ctl & msk[5][7:0]);
      @(posedge pclk);
      ld <= 1'b1;
      cv <= c;
      @(posedge pclk);
      ld <= 1'b0;
      @(posedge pclk);
      #1;
      chk(cmd_stop, |s);
      chk(cmd_start, |(st & ctl & msk[3][7:0]) & ~|s);
      chk(cmd_jog, |(jg & ctl & msk[4][7:0]));
      chk({cmd_fwd, cmd_rev}, {f & ~r, r & ~f});
      chk(cmd_fclr, |(fc & ctl & msk[6][7:0]));
      chk(write_grant, wq & wa);
      chk(write_refuse, wq & ~wa);
   endtask

   // Let the curve settle at one operating point, then compare.
   task automatic vchk(input int f, input logic a, input int e);
      @(posedge pclk);
      out_freq <= f;
      accelerating <= a;
      repeat (6) @(posedge pclk);
      #1;
      chk(vhz_voltage, e);
   endtask

   task automatic tally_and_finish();
      if (error_cnt == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Free-running 100 MHz clock.
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // The whole run needs about five microseconds; this cuts a hang short.
   initial begin
      #200us;
      error_cnt++;
      tally_and_finish();
   end

   // Main sequence: reset values, write mask staging, gating, modes, curve.
   initial begin
      {psel, penable, pwrite, drive_reset, direction_test} = '0;
      {accelerating, ld, paddr, pwdata, out_freq, cv} = '0;
      error_cnt = 0;
      n_tests = 0;
      presetn = 1'b0;
      foreach (msk[i]) msk[i] = (i < 7) ? 32'h00AF : 0;
      msk[12] = 32'h0190;
      msk[13] = 32'h003C;
      act = 32'h00AF;
      b15 = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      void'($urandom(32'h07A8A6BF));
      for (int a = 0; a <= 8'h34; a += 4) rreg(a);
      apb(1'b0, 8'h40, 0);
      chk(er, 1'b1);
      chk(rd, 0);
      apb(1'b1, 8'h0A, 32'hFFFF);
      chk(er, 1'b1);
      v = '0;
      foreach (v[i]) v[i].wr = 1'b1;
      send(v);
      wreg(8'h00, 32'h0002);
      rreg(8'h04);
      send(v);
      @(posedge pclk);
      drive_reset <= 1'b1;
      @(posedge pclk);
      drive_reset <= 1'b0;
      act = msk[0];
      send(v);
      wreg(8'h00, 32'h00A0);
      wreg(8'h04, 32'h8000);
      rreg(8'h04);
      wreg(8'h04, 32'h0000);
      rreg(8'h04);
      send(v);
      for (int n = 0; n < 40; n++) begin
         wreg(8'h08 + 4 * ($urandom % 5), $urandom);
         foreach (v[i]) v[i] = 7'($urandom);
         foreach (v[i]) v[i].stop = ($urandom % 6 == 0) && i != 4 && i != 6;
         v[4].wr = 1'b0;
         v[6].wr = 1'b0;
         send(v);
      end
      for (int a = 8; a <= 8'h18; a += 4) wreg(a, 32'hFFFF);
      v = '0;
      {v[4].start, v[4].jog, v[6].fclr, v[6].fwd} = 4'hF;
      send(v);
      wreg(8'h08, 0);
      v = '0;
      {v[1].stop, v[1].start, v[1].jog, v[3].fclr} = 4'hF;
      send(v);
      for (int m = 0; m <= 5; m++) begin
         wreg(8'h1C, m);
         rreg(8'h1C);
         chk(drive_mode, msk[7]);
      end
      wreg(8'h1C, 3);
      @(posedge pclk);
      direction_test <= 1'b1;
      @(posedge pclk);
      direction_test <= 1'b0;
      repeat (3) @(posedge pclk);
      #1;
      chk(drive_mode, 3'h4);
      msk[7] = 4;
      rreg(8'h1C);
      wreg(8'h1C, 3);
      vchk(30, 1'b0, 200);
      vchk(60, 1'b0, 400);
      wreg(8'h20, 100);
      wreg(8'h24, 40);
      vchk(0, 1'b1, 100);
      vchk(0, 1'b0, 40);
      vchk(30, 1'b0, 220);
      wreg(8'h2C, 20);
      wreg(8'h28, 200);
      vchk(10, 1'b0, 120);
      vchk(40, 1'b0, 300);
      wreg(8'h1C, 0);
      vchk(30, 1'b0, 0);
      tally_and_finish();
   end
endmodule // pcg_gating_tb

bind pcg_gating pcg_gating_monitor #(.NPORTS(NPORTS))
   i_pcg_gating_monitor (.*);

// ### pcg_pkg.sv
// Shared constants and types of the port command gating block.
// Assumes a single pclk domain and an APB master with 32-bit data.
// Notes on behaviour
// - A mask bit of 1 passes that port's command; 0 blocks it.
// - Write mask decides which ports may change parameters; others refused.
// - New write mask applies on reset, drive reset, or security bit fall; reset loads RST_MASK into both write masks instead.
// - Control mask 0 blocks all control functions from a port except stop.
// - Start commands pass only from ports set in the start mask.
// - Jog requests pass only from ports set in the jog mask.
// - Direction commands pass only from ports set in the direction mask.
// - Fault clears pass only from ports set in the fault-clear mask.
// - Bits 0,1,2,3,5,7 are terminal, panel, external, auxiliary, adapter, ctrl.
// - Mode codes 0..4: vector, vector thermal, magnet, volts-hertz, test.
// - Direction test step forces the mode selector to test by itself.
// - Default volts-hertz curve is a line from zero to rated point.
// - Curve shaped by three programmable points joined by linear segments.
// - At low speed, not accelerating, boost drops to the run boost level.
package pcg_pkg;

   localparam int NPORTS = 8;

   // Register byte offsets.
   localparam logic [7:0] OFS_WRITE_PEND  = 8'h00;
   localparam logic [7:0] OFS_WRITE_ACT   = 8'h04;
   localparam logic [7:0] OFS_CONTROL     = 8'h08;
   localparam logic [7:0] OFS_START       = 8'h0C;
   localparam logic [7:0] OFS_INCH        = 8'h10;
   localparam logic [7:0] OFS_ROTATION    = 8'h14;
   localparam logic [7:0] OFS_ERR_CLEAR   = 8'h18;
   localparam logic [7:0] OFS_ALGORITHM   = 8'h1C;
   localparam logic [7:0] OFS_START_BOOST = 8'h20;
   localparam logic [7:0] OFS_RUN_BOOST   = 8'h24;
   localparam logic [7:0] OFS_BREAK_VOLT  = 8'h28;
   localparam logic [7:0] OFS_BREAK_FREQ  = 8'h2C;
   localparam logic [7:0] OFS_RATED_VOLT  = 8'h30;
   localparam logic [7:0] OFS_RATED_FREQ  = 8'h34;
   localparam logic [7:0] OFS_STATUS      = 8'h38;
   localparam logic [7:0] OFS_VOLTAGE     = 8'h3C;

   // Source bit positions inside every mask, and the security bit of the active write mask.
   localparam int BIT_TERMINAL   = 0;
   localparam int BIT_PANEL      = 1;
   localparam int BIT_EXTERNAL   = 2;
   localparam int BIT_AUXILIARY  = 3;
   localparam int BIT_ADAPTER    = 5;
   localparam int BIT_CONTROLLER = 7;
   localparam int BIT_SECURITY   = 15;

   // Bits that name a real source; all others are reserved.
   localparam logic [15:0] SOURCE_BITS = 16'h00AF;

   // Reset values.
   localparam logic [15:0] RST_MASK        = 16'h00AF;
   localparam logic [15:0] RST_START_BOOST = 16'h0000;
   localparam logic [15:0] RST_RUN_BOOST   = 16'h0000;
   localparam logic [15:0] RST_BREAK_VOLT  = 16'h0000;
   localparam logic [15:0] RST_BREAK_FREQ  = 16'h0000;
   localparam logic [15:0] RST_RATED_VOLT  = 16'h0190;
   localparam logic [15:0] RST_RATED_FREQ  = 16'h003C;

   // Motor control algorithm codes.
   typedef enum logic [2:0] {
      MODE_VECTOR  = 3'h0,
      MODE_THERMAL = 3'h1,
      MODE_MAGNET  = 3'h2,
      MODE_VHZ     = 3'h3,
      MODE_TEST    = 3'h4
   } pcg_mode_t;

   // One port's command word.
   typedef struct packed {
      logic stop;
      logic start;
      logic jog;
      logic fwd;
      logic rev;
      logic fclr;
      logic wr;
   } pcg_cmd_t;

   // Volts-hertz curve settings handed to the curve module.
   typedef struct packed {
      logic [15:0] start_boost;
      logic [15:0] run_boost;
      logic [15:0] break_volt;
      logic [15:0] break_freq;
      logic [15:0] rated_volt;
      logic [15:0] rated_freq;
   } pcg_curve_t;

endpackage

// ### pcg_src_model.sv
// Model of the command sources standing on every port of the gate.
// Assumes the bench hands over a command set with a one-cycle load.
module pcg_src_model #(
   parameter int NPORTS = 8
) (
   input  wire logic                           pclk,
   input  wire logic                           presetn,
   input  wire logic                           load,
   input  wire pcg_pkg::pcg_cmd_t [NPORTS-1:0] cmds,
   output pcg_pkg::pcg_cmd_t      [NPORTS-1:0] port_cmd
);
   // A source holds a command one cycle, then idles, so a gate that
   // keeps a stale level shows up as a wrong result.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_cmd <= '0;
      end else begin
         port_cmd <= load ? cmds : '0;
      end
   end
endmodule // pcg_src_model

// ### pcg_vhz_curve.sv
// Volts-hertz curve generator: turns an output frequency into a voltage.
// Assumes frequency and settings are stable over a few pclk cycles.
module pcg_vhz_curve (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               enable,
   input  wire logic               accelerating,
   input  wire logic [15:0]        freq,
   input  wire pcg_pkg::pcg_curve_t curve,
   output logic      [15:0]        voltage
);

   logic [15:0] boost;
   logic [15:0] v0;
   logic [15:0] v1;
   logic [15:0] f0;
   logic [15:0] f1;
   logic [15:0] v_next;

   // Linear step between two points; a flat segment gives its start.
   function automatic logic [15:0] interp(
      input logic [15:0] va, input logic [15:0] vb,
      input logic [15:0] fa, input logic [15:0] fb,
      input logic [15:0] f);
      logic signed [17:0] dv;
      logic signed [33:0] prod;
      logic signed [33:0] span;
      dv = $signed({2'b00, vb}) - $signed({2'b00, va});
      prod = dv * $signed({18'h00000, f - fa});
      span = $signed({18'h00000, fb - fa});
      if (fb <= fa) begin
         interp = va;
      end else begin
         interp = 16'(34'($signed({18'h00000, va}) + prod / span));
      end
   endfunction

   // The starting point drops to run boost once acceleration ends.
   always_comb begin
      boost = accelerating ? curve.start_boost : curve.run_boost;
      if (freq < curve.break_freq) begin
         v0 = boost;
         f0 = 16'h0000;
         v1 = curve.break_volt;
         f1 = curve.break_freq;
      end else begin
         v0 = (curve.break_freq == 16'h0000) ? boost : curve.break_volt;
         f0 = curve.break_freq;
         v1 = curve.rated_volt;
         f1 = curve.rated_freq;
      end
      if (freq >= curve.rated_freq) begin
         v_next = curve.rated_volt;
      end else begin
         v_next = interp(v0, v1, f0, f1, freq);
      end
   end

   // Output is held at zero outside volts-hertz operation.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         voltage <= 16'h0000;
      end else begin
         voltage <= enable ? v_next : 16'h0000;
      end
   end

endmodule // pcg_vhz_curve
